/* rtl/osc_pkg.sv */
/*
 * Shared constants, types and register map of the sequence controller.
 * Assumes a single 200 MHz clock and 32-bit classic Wishbone access.
 */
// Behaviour
// - Three modes are kept: idle for normal output, run, and hold.
// - In hold the step and its timing stay frozen.
// - Start in idle enters run at step 1.
// - Start after a pause resumes where execution stopped; a pause in the end cycle of a counted jump step still advances its jump counter.
// - Start after an end-action hold resumes at that step's jump destination.
// - Pause moves run into hold.
// - Stop enters idle at once and selects the normal output step.
// - Stop copies the live output values into the normal step parameters.
// - Copied voltage or frequency out of range becomes the range lower limit.
// - Branch goes to the current step's branch destination.
// - Loops use per-step jump destination, count and counter.
// - A loop closed by jump count N runs N plus one times; jump count zero repeats it without end.
// - Step sync code drives the control output; zero in normal output.
// - With end phase enabled, step lasts its time plus wait for phase zero.
// - During the phase-zero wait the step's final settings stay applied.
// - Step end action continues, enters hold, or returns to idle.
// - Jump destination zero means next step; 1 to 255 names a step.
// - An end action other than continue takes priority over the jump.
package osc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 100000; // Step time resolution, 0.1 ms
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_NORM_DC = 8'h08;
    localparam logic [7:0] REG_NORM_AC = 8'h0C;
    localparam logic [7:0] REG_NORM_FREQ = 8'h10;

    // Command bits of the control register
    localparam int CMD_START = 0;
    localparam int CMD_PAUSE = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_BRANCH = 3;

    // Status field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STEP_LSB = 8;
    localparam int ST_PHWAIT = 16;
    localparam int ST_ENDHOLD = 17;

    // Normal step reset values (0.1 V, 0.1 Hz units)
    localparam logic [15:0] NORM_DC_RST = 16'h0000;
    localparam logic [15:0] NORM_AC_RST = 16'h0000;
    localparam logic [15:0] NORM_FREQ_RST = 16'h01F4;

    // Setting ranges; DC is signed
    localparam logic [15:0] DC_MIN = 16'hF060;
    localparam logic [15:0] DC_MAX = 16'h0FA0;
    localparam logic [15:0] AC_MIN = 16'h0000;
    localparam logic [15:0] AC_MAX = 16'h1F40;
    localparam logic [15:0] FREQ_MIN = 16'h000A;
    localparam logic [15:0] FREQ_MAX = 16'h157C;

    localparam logic [7:0] FIRST_STEP = 8'h01;
    localparam logic [7:0] LAST_STEP = 8'hFF;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_RUN = 3'b010,
        MODE_HOLD = 3'b100
    } osc_mode_e;

    typedef enum logic [1:0] {
        END_CONT = 2'b00,
        END_HOLD = 2'b01,
        END_STOP = 2'b10
    } osc_endact_e;

    typedef struct packed {
        logic [23:0] timeTicks;
        logic endPhase;
        osc_endact_e endAct;
        logic [7:0] jumpStep;
        logic [9:0] jumpTimes;
        logic [7:0] branchStep;
        logic [1:0] syncCode;
    } osc_step_s;

    typedef struct packed {
        logic [15:0] dc;
        logic [15:0] ac;
        logic [15:0] freq;
    } osc_out_s;

endpackage

/* rtl/osc_step_timer.sv */
/*
 * Step duration timer counting 0.1 ms ticks.
 * Assumes load is a one-cycle pulse and run gates counting.
 */
`timescale 1ns/100ps
module osc_step_timer #(
    parameter int TICK_CYC = 20000
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic run,
    input wire logic [23:0] length,
    output logic expired
);
    logic [15:0] pre_q;
    logic [23:0] ticks_q;
    logic tick;

    // ----------------------------------------
    // Tick generation and count
    // ----------------------------------------
    assign tick = run && (pre_q == 16'(TICK_CYC - 1));
    assign expired = (ticks_q >= length);

    // Prescaler, restarted with every new step
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 16'h0000;
        end else if (load || tick) begin
            pre_q <= 16'h0000;
        end else if (run) begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    // Elapsed ticks, stops at the step length
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ticks_q <= 24'h000000;
        end else if (load) begin
            ticks_q <= 24'h000000;
        end else if (tick && !expired) begin
            ticks_q <= ticks_q + 24'h000001;
        end
    end
endmodule

/* rtl/osc_seq_ctrl.sv */
/*
 * Sequence execution controller with a classic Wishbone register slave.
 * Assumes the step store answers stepIn for stepNum in the same cycle and
 * that liveOut and phaseZero come from synthesis logic on the same clock.
 */
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
module osc_seq_ctrl #(
    parameter int TICK_CYC = osc_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire osc_pkg::osc_step_s stepIn,
    input wire osc_pkg::osc_out_s liveOut,
    input wire logic phaseZero,
    output logic [7:0] stepNum,
    output logic stepLoad,
    output logic outFreeze,
    output logic phaseWait,
    output logic normalActive,
    output osc_pkg::osc_out_s normOut,
    output logic [1:0] syncOut
);
    import osc_pkg::*;

    osc_mode_e mode_q, mode_d;
    logic [7:0] step_q, step_d, resume_q, resume_d;
    logic endHold_q, endHold_d, load_q, load_d, ack_q;
    logic [1:0] sync_q;
    logic [31:0] rdat_q;
    osc_out_s norm_q;
    logic [9:0] jumpCnt [256];
    logic [255:0] cntValid_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire wbReq = wbCyc && wbStb;
    wire wbWr = wbReq && wbWe && ack_q;
    wire ctrlWr = wbWr && (wbAdr == REG_CTRL) && wbSel[0];
    wire cmdStart = ctrlWr && wbDatI[CMD_START];
    wire cmdPause = ctrlWr && wbDatI[CMD_PAUSE];
    wire cmdStop = ctrlWr && wbDatI[CMD_STOP];
    wire cmdBranch = ctrlWr && wbDatI[CMD_BRANCH];
    wire anyCmd = cmdStart || cmdPause || cmdStop || cmdBranch;

    // ----------------------------------------
    // Step end and sequencing terms
    // ----------------------------------------
    wire inRun = (mode_q == MODE_RUN);
    wire inHold = (mode_q == MODE_HOLD);
    wire inIdle = (mode_q == MODE_IDLE);
    wire expired;
    wire waitPhase = inRun && expired && stepIn.endPhase && !phaseZero;
    wire stepEnd = inRun && expired && (!stepIn.endPhase || phaseZero);
    wire [9:0] cntNow = cntValid_q[step_q] ? jumpCnt[step_q] : 10'h000;
    wire hasJump = (stepIn.jumpStep != 8'h00);
    wire jumpTake = hasJump && ((stepIn.jumpTimes == 10'h000)
        || (cntNow < stepIn.jumpTimes));
    wire lastStep = (step_q == LAST_STEP);
    wire seqDone = !jumpTake && lastStep;
    wire [7:0] nextStep = jumpTake ? stepIn.jumpStep : step_q + 8'h01;
    wire [7:0] holdDest = hasJump ? stepIn.jumpStep : step_q + 8'h01;
    wire cntUpdate = stepEnd && (stepIn.endAct == END_CONT) && hasJump;
    wire doBranch = cmdBranch && inRun && (stepIn.branchStep != 8'h00);
    // Step-end return to idle yields to branch and pause; stop beats all
    wire endIdle = stepEnd && ((stepIn.endAct == END_STOP)
        || ((stepIn.endAct == END_CONT) && seqDone)) && !doBranch && !cmdPause;
    wire goIdle = cmdStop || endIdle
        || (cmdStart && inHold && endHold_q && lastStep && !hasJump);

    // ----------------------------------------
    // Out-of-range replacement
    // ----------------------------------------
    function automatic logic [15:0] clampLow(input logic [15:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi,
                                             input logic sgn);
        logic bad;
        bad = sgn ? (($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi)))
                  : ((v < lo) || (v > hi));
        return bad ? lo : v;
    endfunction

    // ----------------------------------------
    // Mode and step next-state
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        step_d = step_q;
        resume_d = resume_q;
        endHold_d = endHold_q;
        load_d = 1'b0;
        if (goIdle) begin
            mode_d = MODE_IDLE;
            endHold_d = 1'b0;
        end else if (doBranch) begin
            step_d = stepIn.branchStep;
            load_d = 1'b1;
        end else if (cmdPause && inRun) begin
            mode_d = MODE_HOLD;
            endHold_d = 1'b0;
        end else if (cmdStart && inIdle) begin
            mode_d = MODE_RUN;
            step_d = FIRST_STEP;
            load_d = 1'b1;
        end else if (cmdStart && inHold) begin
            mode_d = MODE_RUN;
            endHold_d = 1'b0;
            if (endHold_q) begin
                step_d = resume_q;
                load_d = 1'b1;
            end
        end else if (stepEnd) begin
            case (stepIn.endAct)
                END_HOLD: begin
                    mode_d = MODE_HOLD;
                    endHold_d = 1'b1;
                    resume_d = holdDest;
                end
                END_CONT: begin
                    step_d = nextStep;
                    load_d = 1'b1;
                end
                default: begin
                    mode_d = MODE_IDLE;
                end
            endcase
        end
    end

    // Mode, step and resume point registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_IDLE;
            step_q <= FIRST_STEP;
            resume_q <= FIRST_STEP;
            endHold_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            step_q <= step_d;
            resume_q <= resume_d;
            endHold_q <= endHold_d;
            load_q <= load_d;
        end
    end

    // ----------------------------------------
    // Per-step jump counters
    // ----------------------------------------
    // Valid bits stand in for a reset of the counter array
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cntValid_q <= '0;
        end else if (cmdStart && inIdle) begin
            cntValid_q <= '0;
        end else if (cntUpdate) begin
            cntValid_q[step_q] <= 1'b1;
        end
    end

    // Counter counts jumps, then rearms for an outer loop
    always_ff @(posedge clock) begin
        if (cntUpdate && stepIn.jumpTimes != 10'h000) begin
            jumpCnt[step_q] <= jumpTake ? cntNow + 10'h001 : 10'h000;
        end
    end

    // ----------------------------------------
    // Step timer, frozen outside run
    // ----------------------------------------
    osc_step_timer #(.TICK_CYC(TICK_CYC)) u_timer (
        .clock(clock),
        .rstn(rstn),
        .load(load_d),
        .run(inRun && !load_q),
        .length(stepIn.timeTicks),
        .expired(expired)
    );

    // ----------------------------------------
    // Normal step parameters and sync output
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            norm_q <= '{dc: NORM_DC_RST, ac: NORM_AC_RST, freq: NORM_FREQ_RST};
        end else if (goIdle && !inIdle) begin
            norm_q.dc <= clampLow(liveOut.dc, DC_MIN, DC_MAX, 1'b1);
            norm_q.ac <= clampLow(liveOut.ac, AC_MIN, AC_MAX, 1'b0);
            norm_q.freq <= clampLow(liveOut.freq, FREQ_MIN, FREQ_MAX, 1'b0);
        end else if (wbWr && wbAdr == REG_NORM_DC) begin
            if (wbSel[0]) norm_q.dc[7:0] <= wbDatI[7:0];
            if (wbSel[1]) norm_q.dc[15:8] <= wbDatI[15:8];
        end else if (wbWr && wbAdr == REG_NORM_AC) begin
            if (wbSel[0]) norm_q.ac[7:0] <= wbDatI[7:0];
            if (wbSel[1]) norm_q.ac[15:8] <= wbDatI[15:8];
        end else if (wbWr && wbAdr == REG_NORM_FREQ) begin
            if (wbSel[0]) norm_q.freq[7:0] <= wbDatI[7:0];
            if (wbSel[1]) norm_q.freq[15:8] <= wbDatI[15:8];
        end
    end

    // Sync code follows the executing step
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_q <= 2'b00;
        end else begin
            sync_q <= inIdle ? 2'b00 : stepIn.syncCode;
        end
    end

    // ----------------------------------------
    // Wishbone read path and acknowledge
    // ----------------------------------------
    wire [31:0] statusWord = {14'h0000, endHold_q, waitPhase, step_q, 5'h00, mode_q};
    wire [31:0] rdSel = (wbAdr == REG_STATUS) ? statusWord :
                        (wbAdr == REG_NORM_DC) ? {16'h0000, norm_q.dc} :
                        (wbAdr == REG_NORM_AC) ? {16'h0000, norm_q.ac} :
                        (wbAdr == REG_NORM_FREQ) ? {16'h0000, norm_q.freq} :
                        32'h00000000;

    // One wait state; unmapped reads return zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= wbReq && !ack_q;
            rdat_q <= rdSel;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wbAck = ack_q;
    assign wbDatO = rdat_q;
    assign stepNum = step_q;
    assign stepLoad = load_q;
    assign outFreeze = inHold;
    assign phaseWait = waitPhase;
    assign normalActive = inIdle;
    assign normOut = norm_q;
    assign syncOut = sync_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_start_from_idle: assert property (@(posedge clock) disable iff (!rstn)
        (inIdle && cmdStart && !cmdStop) |=> (inRun && step_q == FIRST_STEP && stepLoad))
        else $error("start in idle did not run step 1");

    a_pause_enters_hold: assert property (@(posedge clock) disable iff (!rstn)
        (inRun && cmdPause && !cmdStop && !doBranch) |=> inHold)
        else $error("pause did not enter hold");

    a_pause_ignored: assert property (@(posedge clock) disable iff (!rstn)
        (!inRun && cmdPause && !cmdStart && !cmdStop) |=> $stable(mode_q) && $stable(step_q))
        else $error("pause outside run changed state");

    a_hold_frozen: assert property (@(posedge clock) disable iff (!rstn)
        (inHold && !anyCmd) |=> $stable(step_q) && !stepLoad)
        else $error("step moved during hold");

    a_stop_to_idle: assert property (@(posedge clock) disable iff (!rstn)
        cmdStop |=> normalActive ##1 (syncOut == 2'b00))
        else $error("stop did not return to normal output");

    a_stop_freq_clamp: assert property (@(posedge clock) disable iff (!rstn)
        (cmdStop && !inIdle && (liveOut.freq > FREQ_MAX || liveOut.freq < FREQ_MIN))
        |=> (normOut.freq == FREQ_MIN))
        else $error("out of range frequency not replaced");

    a_resume_end_hold: assert property (@(posedge clock) disable iff (!rstn)
        (inHold && endHold_q && cmdStart && !cmdStop && !goIdle)
        |=> (step_q == $past(resume_q) && stepLoad))
        else $error("end-hold resume at wrong step");

    a_phase_wait_keep: assert property (@(posedge clock) disable iff (!rstn)
        (waitPhase && !anyCmd) |=> $stable(step_q) && inRun)
        else $error("step left during phase wait");

    a_branch_target: assert property (@(posedge clock) disable iff (!rstn)
        (doBranch && !cmdStop) |=> (step_q == $past(stepIn.branchStep)))
        else $error("branch went to wrong step");

    a_jump_loop: assert property (@(posedge clock) disable iff (!rstn)
        (cntUpdate && !anyCmd && stepIn.jumpTimes != 10'h000 && cntNow == stepIn.jumpTimes)
        |=> (step_q != $past(stepIn.jumpStep) || $past(step_q) + 8'h01 == step_q))
        else $error("loop ran past its jump count");
endmodule

/* sim/osc_step_model.sv */
/*
 * Far-side model: step parameter store, live output values, phase source.
 * Assumes the bench fills steps, live and phEn by hierarchical access.
 */
`timescale 1ns/100ps
module osc_step_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] stepNum,
    output osc_pkg::osc_step_s stepIn,
    output osc_pkg::osc_out_s liveOut,
    output logic phaseZero
);
    import osc_pkg::*;
    // Empty store and quiet outputs until the bench loads them
    osc_step_s steps [256] = '{default: '0};
    osc_out_s live = '0;
    logic phEn = 1'b0;
    logic [3:0] phCnt;
    // -------------------------------------
    // Store answers in the same cycle
    // -------------------------------------
    assign stepIn = steps[stepNum];
    assign liveOut = live;
    // Phase reaches zero once every 16 cycles, only while enabled
    assign phaseZero = phEn && (phCnt == 4'h0);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phCnt <= 4'h0;
        end else begin
            phCnt <= phCnt + 4'h1;
        end
    end
endmodule

/* sim/testbench.sv */
/*
 * Self-checking bench of the sequence controller with a queue model.
 * Assumes the step store model and the controller package.
 */
`timescale 1ns/100ps
module testbench;
    import osc_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [31:0] wbDatO;
    logic wbAck, stepLoad, outFreeze, phaseWait, normalActive, phaseZero;
    logic [7:0] stepNum;
    logic [1:0] syncOut;
    osc_step_s stepIn;
    osc_out_s liveOut, normOut, tmp;
    logic [31:0] rd, r;
    logic [31:0] lfsrQ = 32'hFE395501;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int res, res2;
    logic [7:0] path[$];
    int expPath[$];
    int cnt[256];

    always #2.5 clock = ~clock;

    osc_seq_ctrl #(.TICK_CYC(4)) uut (.clock(clock), .rstn(rstn), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAck(wbAck), .stepIn(stepIn), .liveOut(liveOut),
        .phaseZero(phaseZero), .stepNum(stepNum), .stepLoad(stepLoad),
        .outFreeze(outFreeze), .phaseWait(phaseWait), .normalActive(normalActive),
        .normOut(normOut), .syncOut(syncOut));
    osc_step_model store (.clock(clock), .rstn(rstn), .stepNum(stepNum),
        .stepIn(stepIn), .liveOut(liveOut), .phaseZero(phaseZero));

    // -------------------------------------
    // Helpers
    // -------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] stat(input logic eh, input logic [7:0] s,
        input logic [2:0] m);
        return {14'h0, eh, 1'b0, s, 5'h0, m};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled high
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatI <= dat;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 40);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 40) begin
            n_errors++;
            $display("ERROR t=%0t no bus ack", $time);
        end
    endtask
    task automatic cmd(input logic [31:0] bits);
        wbXfer(1'b1, REG_CTRL, bits);
        @(posedge clock);
    endtask
    task automatic waitSig(input int w, input int lim);
        int n;
        n = 0;
        while ((w == 0 ? outFreeze : w == 1 ? phaseWait : normalActive) !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) begin
            n_errors++;
            $display("ERROR t=%0t wait %0d expired", $time, w);
        end
    endtask
    task automatic setStep(input int i, input int t, input logic ph, input osc_endact_e a,
        input int j, input int jt, input int br, input int sy);
        store.steps[i] = {24'(t), ph, a, 8'(j), 10'(jt), 8'(br), 2'(sy)};
    endtask
    // Reference walk of the step table with per-step jump counters
    task automatic modelRun(input int s0, output int resume);
        int s;
        osc_step_s st;
        s = s0;
        resume = 0;
        for (int k = 0; k < 100; k++) begin
            st = store.steps[s];
            expPath.push_back(s);
            if (st.endAct == END_HOLD) begin
                resume = (st.jumpStep != 8'h00) ? int'(st.jumpStep) : s + 1;
                break;
            end
            if (st.endAct == END_STOP) break;
            if (st.jumpStep != 8'h00 && (st.jumpTimes == 0 || cnt[s] < int'(st.jumpTimes))) begin
                cnt[s]++;
                s = st.jumpStep;
            end else begin
                cnt[s] = 0;
                s++;
            end
            if (s > 255) break;
        end
    endtask
    task automatic cmpPath();
        chk(path.size(), expPath.size());
        foreach (expPath[i]) begin
            if (i < path.size()) chk(path[i], expPath[i]);
        end
        path.delete();
        expPath.delete();
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Steps entered, as seen with the load pulse
    always @(posedge clock) begin
        if (stepLoad === 1'b1) path.push_back(stepNum);
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("ERROR t=%0t timeout", $time);
            results();
        end
    end

    // -------------------------------------
    // Main sequence
    // -------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        setStep(1, 5, 1'b0, END_CONT, 0, 0, 4, 1);
        setStep(2, 2, 1'b0, END_CONT, 1, 2, 4, 2);
        setStep(3, 3, 1'b0, END_HOLD, 5, 0, 0, 3);
        setStep(4, 60, 1'b0, END_CONT, 0, 0, 0, 2);
        setStep(5, 1, 1'b1, END_STOP, 0, 0, 0, 1);
        // Register reset values, read-back, unmapped and write-only places
        wbXfer(1'b0, REG_NORM_DC, 32'h0);
        chk(rd, {16'h0, NORM_DC_RST});
        wbXfer(1'b0, REG_NORM_AC, 32'h0);
        chk(rd, {16'h0, NORM_AC_RST});
        wbXfer(1'b0, REG_NORM_FREQ, 32'h0);
        chk(rd, {16'h0, NORM_FREQ_RST});
        r = lfsr(lfsrQ);
        lfsrQ = r;
        wbXfer(1'b1, REG_NORM_FREQ, {16'hFFFF, 16'(10 + r % 5491)});
        wbXfer(1'b0, REG_NORM_FREQ, 32'h0);
        chk(rd, {16'h0, 16'(10 + r % 5491)});
        wbXfer(1'b1, 8'h40, 32'hFFFFFFFF);
        wbXfer(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        wbXfer(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        wbXfer(1'b0, REG_STATUS, 32'h0);
        chk(rd, stat(1'b0, 8'h01, MODE_IDLE));
        $display("test 0 done");
        // Loop walk into end-action hold, then resume at jump destination
        r = lfsr(lfsrQ);
        lfsrQ = r;
        tmp = {16'(int'(r % 8001) - 4000), 16'(r[15:0] % 8001), 16'(10 + r[31:16] % 5491)};
        store.live <= tmp;
        foreach (cnt[i]) cnt[i] = 0;
        path.delete();
        cmd(32'h1);
        waitSig(0, 600);
        modelRun(1, res);
        cmpPath();
        wbXfer(1'b0, REG_STATUS, 32'h0);
        chk(rd, stat(1'b1, 8'h03, MODE_HOLD));
        chk(syncOut, 2'd3);
        cmd(32'h1);
        waitSig(1, 100);
        modelRun(res, res2);
        chk(stepNum, 8'h05);
        repeat (20) @(posedge clock);
        chk({phaseWait, stepNum}, {1'b1, 8'h05});
        store.phEn <= 1'b1;
        waitSig(2, 100);
        cmpPath();
        chk(normOut, tmp);
        @(posedge clock);
        chk(syncOut, 2'd0);
        $display("test 1 done");
        // Pause, ignored pause, resume, branch, stop with clamping
        cmd(32'h1);
        cmd(32'h2);
        chk(outFreeze, 1'b1);
        repeat (30) @(posedge clock);
        chk(stepNum, 8'h01);
        cmd(32'h2);
        wbXfer(1'b0, REG_STATUS, 32'h0);
        chk(rd, stat(1'b0, 8'h01, MODE_HOLD));
        cmd(32'h1);
        wbXfer(1'b0, REG_STATUS, 32'h0);
        chk(rd, stat(1'b0, 8'h01, MODE_RUN));
        cmd(32'h8);
        chk(stepNum, 8'h04);
        repeat (3) @(posedge clock);
        chk(syncOut, 2'd2);
        r = lfsr(lfsrQ);
        lfsrQ = r;
        tmp = {16'h2000, 16'(r % 8001), 16'h0005};
        store.live <= tmp;
        cmd(32'h4);
        chk(normalActive, 1'b1);
        chk(normOut, {DC_MIN, tmp.ac, FREQ_MIN});
        @(posedge clock);
        chk(syncOut, 2'd0);
        cmd(32'h2);
        chk({normalActive, outFreeze}, 2'b10);
        $display("test 2 done");
        results();
    end
endmodule
